// ---- rtl/flow_ctrl_consts.svh ----
// Constants for the program-flow and system-control block
`ifndef FLOW_CTRL_CONSTS_SVH
`define FLOW_CTRL_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define OFS_COMMAND   8'h00
`define OFS_PC        8'h04
`define OFS_SP        8'h08
`define OFS_ACC       8'h0c
`define OFS_FLAGS     8'h10
`define OFS_STATUS    8'h14
`define OFS_WDT       8'h18

// -----------------------------------------------------------------
// Command word fields
// -----------------------------------------------------------------
`define CMD_OP_LSB    0
`define CMD_SKIP_BIT  4
`define CMD_IMM_LSB   8
`define CMD_TGT_LSB   16

// -----------------------------------------------------------------
// Widths, reset values and steps
// -----------------------------------------------------------------
`define PC_W          12
`define STACK_DEPTH   64
`define PC_RESET      12'h000
`define SP_RESET      8'h00
`define ACC_RESET     8'h00
`define GIE_RESET     1'b0
`define SP_STEP       8'h02
`define CYC_ONE       2'h1
`define CYC_TWO       2'h2

`endif

// ---- rtl/flow_ctrl_pkg.sv ----
// Types shared by the program-flow and system-control block
package flow_ctrl_pkg;

  // Command opcodes, numbered in order from 0
  typedef enum logic [3:0] {
    OP_NOP, OP_GOTO, OP_CALL, OP_RET, OP_RET_IMM, OP_RETI, OP_PCADD,
    OP_ENGINT, OP_DISGINT, OP_STOPSYS, OP_STOPEXE, OP_RESET,
    OP_WDRESET, OP_IDXM, OP_SKIP, OP_OTHER
  } opcode_type;

  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE, ST_SECOND
  } state_type;

  // Arithmetic flags held for the datapath
  typedef struct packed {
    logic overflow_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic zero_flag;
  } flags_type;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage

// ---- rtl/cpu_flow_system_control.sv ----
// Program-flow and system-control sequencer with an APB register port
`timescale 1ns/1ps
`include "flow_ctrl_consts.svh"

module cpu_flow_system_control (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire flow_ctrl_pkg::apb_req_type apb_req,
  output      flow_ctrl_pkg::apb_rsp_type apb_rsp,
  // Wake-up from either halt
  input  wire logic                       wake_event,
  // System control outputs
  output      logic                       interrupts_allowed,
  output      logic                       osc_enable,
  output      logic                       cpu_clock_enable,
  output      logic                       soft_reset_pulse,
  output      logic                       wdt_clear_pulse
);
  import flow_ctrl_pkg::*;

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  // Architectural state and status
  logic [`PC_W-1:0] program_counter;
  logic [7:0]       stack_pointer;
  logic [7:0]       accumulator;
  flags_type        flags;
  logic             gie;
  logic             sys_halt;
  logic             cpu_halt;
  state_type        state;
  opcode_type       held_op;
  logic [1:0]       last_cycles;
  logic [15:0]      wdt_count;
  logic [7:0]       stack_mem [0:`STACK_DEPTH-1];
  apb_rsp_type      rsp;

  // Next values from the sequencer
  logic [`PC_W-1:0] next_pc;
  logic [7:0]       next_sp;
  logic [7:0]       next_acc;
  logic             next_gie;
  logic             next_sys_halt;
  logic             next_cpu_halt;
  state_type        next_state;
  opcode_type       next_held_op;
  logic [1:0]       next_last_cycles;
  logic [15:0]      next_wdt;
  logic             next_soft_reset;
  logic             next_wdt_clear;
  logic             push_en;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Program counter plus a small step, wrapping over the full space
  function automatic logic [`PC_W-1:0] pc_step(
    input logic [`PC_W-1:0] pc,
    input logic [`PC_W-1:0] step
  );
    pc_step = pc + step;
  endfunction

  // Stack byte index taken from the low bits of an address
  function automatic logic [5:0] stk_idx(input logic [7:0] addr);
    stk_idx = addr[5:0];
  endfunction

  // Instructions that hold the sequencer for a second cycle; a skip
  // does so only when its condition holds
  function automatic logic takes_two(input opcode_type op,
                                     input logic       skip);
    case (op)
      OP_GOTO, OP_CALL, OP_PCADD, OP_RET, OP_RET_IMM, OP_RETI,
      OP_IDXM: takes_two = 1'b1;
      OP_SKIP: takes_two = skip;
      default: takes_two = 1'b0;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  // The answer is registered, so every transfer sees one wait state;
  // pready already high keeps a held access from arming a second answer
  wire        access    = apb_req.psel & apb_req.penable;
  wire        wr_now    = access & apb_req.pwrite & rsp.pready;
  wire        first_acc = access & ~rsp.pready;
  wire [7:0]  addr      = apb_req.paddr;
  wire [31:0] wdata     = apb_req.pwdata;
  wire        hit_cmd   = addr == `OFS_COMMAND;
  wire        hit_pc    = addr == `OFS_PC;
  wire        hit_sp    = addr == `OFS_SP;
  wire        hit_acc   = addr == `OFS_ACC;
  wire        hit_flags = addr == `OFS_FLAGS;
  wire        hit_stat  = addr == `OFS_STATUS;
  wire        hit_wdt   = addr == `OFS_WDT;
  wire        mapped    = hit_cmd | hit_pc | hit_sp | hit_acc |
                          hit_flags | hit_stat | hit_wdt;

  // Software write strobes for the plain registers
  wire        wr_pc     = wr_now & hit_pc;
  wire        wr_sp     = wr_now & hit_sp;
  wire        wr_acc    = wr_now & hit_acc;
  wire        wr_flags  = wr_now & hit_flags;

  // Command fields and acceptance; a halted or busy sequencer drops
  // the command without an error
  wire              halted   = sys_halt | cpu_halt;
  wire              cmd_go   = wr_now & hit_cmd & (state == ST_IDLE) &
                               ~halted;
  wire opcode_type  cmd_op   = opcode_type'(wdata[`CMD_OP_LSB +: 4]);
  wire              cmd_skip = wdata[`CMD_SKIP_BIT];
  wire [7:0]        cmd_imm  = wdata[`CMD_IMM_LSB +: 8];
  wire [`PC_W-1:0]  cmd_tgt  = wdata[`CMD_TGT_LSB +: `PC_W];

  // Return address and popped stack pointer
  wire [`PC_W-1:0]  ret_addr = pc_step(program_counter, `PC_W'(1));
  wire [7:0]        sp_pop   = stack_pointer - `SP_STEP;

  // Stack byte slots; the index wraps inside the 64 bytes, so a call
  // chain deeper than the stack silently overwrites the oldest entry
  wire [5:0]        push_lo  = stk_idx(stack_pointer);
  wire [5:0]        push_hi  = stk_idx(stack_pointer + 8'h01);
  wire [5:0]        pop_lo   = stk_idx(sp_pop);
  wire [5:0]        pop_hi   = stk_idx(sp_pop + 8'h01);
  wire [15:0]       pop_word = {stack_mem[pop_hi], stack_mem[pop_lo]};

  // Second cycle of a two-cycle command; new commands are refused then
  wire        busy        = state == ST_SECOND;

  // Read multiplexer
  wire [31:0] status_word = {24'h0, 1'b0, last_cycles, cpu_halt,
                             sys_halt, gie, 1'b0, busy};
  wire [31:0] rd_word =
      hit_pc    ? {20'h0, program_counter} :
      hit_sp    ? {24'h0, stack_pointer} :
      hit_acc   ? {24'h0, accumulator} :
      hit_flags ? {28'h0, flags} :
      hit_stat  ? status_word :
      hit_wdt   ? {16'h0, wdt_count} : 32'h0;

  // -----------------------------------------------------------------
  // Instruction sequencer next values
  // -----------------------------------------------------------------
  always_comb begin
    next_pc          = program_counter;
    next_sp          = stack_pointer;
    next_acc         = accumulator;
    next_gie         = gie;
    next_sys_halt    = sys_halt;
    next_cpu_halt    = cpu_halt;
    next_state       = state;
    next_held_op     = held_op;
    next_last_cycles = last_cycles;
    // The watchdog count freezes while the system clocks are stopped
    next_wdt         = sys_halt ? wdt_count : wdt_count + 16'h1;
    next_soft_reset  = 1'b0;
    next_wdt_clear   = 1'b0;
    push_en          = 1'b0;
    // Direct register writes from software
    if (wr_pc)
      next_pc = wdata[`PC_W-1:0];
    if (wr_sp)
      next_sp = wdata[7:0];
    if (wr_acc)
      next_acc = wdata[7:0];
    // Wake-up releases either halt; a halt command later in this
    // process still wins when both land in one cycle
    if (wake_event) begin
      next_sys_halt = 1'b0;
      next_cpu_halt = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (cmd_go) begin
          next_held_op     = cmd_op;
          next_last_cycles = `CYC_ONE;
          next_pc          = ret_addr;
          case (cmd_op)
            OP_GOTO: begin
              next_pc = cmd_tgt;
            end
            OP_CALL: begin
              push_en = 1'b1;
              next_pc = cmd_tgt;
              next_sp = stack_pointer + `SP_STEP;
            end
            OP_RET, OP_RETI: begin
              next_sp = sp_pop;
              next_pc = pop_word[`PC_W-1:0];
            end
            OP_RET_IMM: begin
              next_acc = cmd_imm;
              next_sp  = sp_pop;
              next_pc  = pop_word[`PC_W-1:0];
            end
            OP_PCADD: begin
              next_pc = pc_step(program_counter,
                                `PC_W'(accumulator));
            end
            OP_ENGINT: begin
              next_gie = 1'b1;
            end
            OP_DISGINT: begin
              next_gie = 1'b0;
            end
            OP_STOPSYS: begin
              next_sys_halt = 1'b1;
            end
            OP_STOPEXE: begin
              next_cpu_halt = 1'b1;
            end
            OP_RESET: begin
              // Same values as the reset pin; the flag register is
              // left alone since no control instruction touches it
              next_pc         = `PC_RESET;
              next_sp         = `SP_RESET;
              next_acc        = `ACC_RESET;
              next_gie        = `GIE_RESET;
              next_wdt        = 16'h0;
              next_soft_reset = 1'b1;
            end
            OP_WDRESET: begin
              next_wdt       = 16'h0;
              next_wdt_clear = 1'b1;
            end
            OP_SKIP: begin
              if (cmd_skip)
                next_pc = pc_step(program_counter, `PC_W'(2));
            end
            default: begin
              next_pc = ret_addr;
            end
          endcase
          // Two-cycle instructions hold the sequencer one more cycle
          if (takes_two(cmd_op, cmd_skip)) begin
            next_state       = ST_SECOND;
            next_last_cycles = `CYC_TWO;
          end
        end
      end
      ST_SECOND: begin
        // Interrupt return re-enables only after its second cycle
        next_state = ST_IDLE;
        if (held_op == OP_RETI)
          next_gie = 1'b1;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Core registers
  // -----------------------------------------------------------------
  // Sequencer, counters, accumulator and halt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= `PC_RESET;
      stack_pointer   <= `SP_RESET;
      accumulator     <= `ACC_RESET;
      gie             <= `GIE_RESET;
      sys_halt        <= 1'b0;
      cpu_halt        <= 1'b0;
      state           <= ST_IDLE;
      held_op         <= OP_NOP;
      last_cycles     <= `CYC_ONE;
      wdt_count       <= 16'h0;
    end else begin
      program_counter <= next_pc;
      stack_pointer   <= next_sp;
      accumulator     <= next_acc;
      gie             <= next_gie;
      sys_halt        <= next_sys_halt;
      cpu_halt        <= next_cpu_halt;
      state           <= next_state;
      held_op         <= next_held_op;
      last_cycles     <= next_last_cycles;
      wdt_count       <= next_wdt;
    end
  end

  // Flags change only by software write, never by an instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags <= '0;
    else if (wr_flags)
      flags <= flags_type'(wdata[3:0]);
  end

  // Return address pushed low byte first into two stack bytes; the
  // stack has no reset, so a return before any call reads garbage
  always_ff @(posedge pclk) begin
    if (push_en) begin
      stack_mem[push_lo] <= ret_addr[7:0];
      stack_mem[push_hi] <= {4'h0, ret_addr[`PC_W-1:8]};
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  // APB answer: one wait state, read data and error with pready;
  // read data returns to zero between answers so no stale word shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
    end else begin
      rsp.pready  <= first_acc;
      rsp.pslverr <= first_acc & ~mapped;
      rsp.prdata  <= first_acc ? rd_word : 32'h0;
    end
  end

  // System control lines, taken from the next values so that each
  // one changes at the same edge as the state behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupts_allowed <= `GIE_RESET;
      osc_enable         <= 1'b1;
      cpu_clock_enable   <= 1'b1;
      soft_reset_pulse   <= 1'b0;
      wdt_clear_pulse    <= 1'b0;
    end else begin
      interrupts_allowed <= next_gie;
      osc_enable         <= ~next_sys_halt;
      cpu_clock_enable   <= ~(next_sys_halt | next_cpu_halt);
      soft_reset_pulse   <= next_soft_reset;
      wdt_clear_pulse    <= next_wdt_clear;
    end
  end

  // Answer leaves straight from its register
  assign apb_rsp = rsp;

endmodule // cpu_flow_system_control

// ---- verif/flow_ctrl_props.sv ----
// Port checker for the flow-control sequencer
`timescale 1ns/1ps
module flow_ctrl_props (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // Bus and wake
  input wire flow_ctrl_pkg::apb_req_type apb_req,
  input wire flow_ctrl_pkg::apb_rsp_type apb_rsp,
  input wire logic                       wake_event,
  // Control outputs
  input wire logic                       interrupts_allowed,
  input wire logic                       osc_enable,
  input wire logic                       cpu_clock_enable,
  input wire logic                       soft_reset_pulse,
  input wire logic                       wdt_clear_pulse
);
  import flow_ctrl_pkg::*;
  // Command write completed while running, and its opcode
  wire       cmd_done = apb_req.psel & apb_req.penable & apb_req.pwrite
    & apb_rsp.pready & ~apb_rsp.pslverr & (apb_req.paddr == 8'h00)
    & cpu_clock_enable;
  wire [3:0] op = apb_req.pwdata[3:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gie_set_a: assert property (
    cmd_done && op == OP_ENGINT |=> interrupts_allowed)
    else $error("enable command left interrupts blocked");
  gie_clear_a: assert property (
    cmd_done && op == OP_DISGINT |=> !interrupts_allowed)
    else $error("disable command left interrupts allowed");
  reti_gie_a: assert property (
    cmd_done && op == OP_RETI |=> $stable(interrupts_allowed) ##1
    interrupts_allowed) else $error("interrupt return enable wrong");
  sys_halt_a: assert property (
    cmd_done && op == OP_STOPSYS |=> !osc_enable && !cpu_clock_enable)
    else $error("system halt left a clock running");
  sys_hold_a: assert property (
    !osc_enable && !wake_event |=> !osc_enable)
    else $error("oscillator restarted without wake");
  cpu_halt_a: assert property (
    cmd_done && op == OP_STOPEXE |=> osc_enable && !cpu_clock_enable)
    else $error("cpu halt clock state wrong");
  wake_run_a: assert property (
    !cpu_clock_enable && wake_event |=> cpu_clock_enable && osc_enable)
    else $error("wake did not restart clocks");
  soft_reset_a: assert property (
    cmd_done && op == OP_RESET |=> soft_reset_pulse &&
    !interrupts_allowed ##1 !soft_reset_pulse)
    else $error("software reset pulse wrong");
  wdt_clear_a: assert property (
    cmd_done && op == OP_WDRESET |=> wdt_clear_pulse ##1 !wdt_clear_pulse)
    else $error("watchdog clear pulse wrong");
endmodule // flow_ctrl_props

bind cpu_flow_system_control flow_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .wake_event(wake_event), .interrupts_allowed(interrupts_allowed),
  .osc_enable(osc_enable), .cpu_clock_enable(cpu_clock_enable),
  .soft_reset_pulse(soft_reset_pulse), .wdt_clear_pulse(wdt_clear_pulse));

// ---- verif/apb_host_model.sv ----
// Bus master standing in for software on the register port
`timescale 1ns/1ps
module apb_host_model (
  // Clock
  input  wire logic                       pclk,
  // Bus
  output      flow_ctrl_pkg::apb_req_type apb_req,
  input  wire flow_ctrl_pkg::apb_rsp_type apb_rsp
);
  import flow_ctrl_pkg::*;
  logic [31:0] rdata;
  logic        rerr;

  initial apb_req = '0;

  // Setup, access held until pready, then release with scrambled data
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '{1'b0, 1'b0, wr, ~a, ~wd};
  endtask
endmodule // apb_host_model

// ---- verif/cpu_flow_system_control_tb_top.sv ----
// Self-checking bench for the flow-control sequencer
`timescale 1ns/1ps
`include "flow_ctrl_consts.svh"
module cpu_flow_system_control_tb_top;
  import flow_ctrl_pkg::*;
  // -----------------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        wake_event;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  logic        ia;
  logic        osc;
  logic        cpu;
  logic        srst;
  logic        wclr;
  int          n_errors;
  int          samples_checked;

  apb_host_model u_host (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));
  cpu_flow_system_control u_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .wake_event(wake_event), .interrupts_allowed(ia), .osc_enable(osc),
    .cpu_clock_enable(cpu), .soft_reset_pulse(srst),
    .wdt_clear_pulse(wclr));

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    u_host.xfer(1'b0, a, 32'h0);
    chk(nm, e, u_host.rdata);
  endtask
  task automatic cmd(input opcode_type op, input logic sk = 1'b0,
                     input logic [7:0] im = 8'h00,
                     input logic [11:0] t = 12'h000);
    wr(`OFS_COMMAND, {4'h0, t, im, 3'h0, sk, op});
  endtask
  // Idle status word with cycle count and global enable
  function automatic logic [31:0] st(input logic [1:0] c, input logic g);
    return {25'h0, c, 2'b00, g, 2'b00};
  endfunction
  // Wake request for one cycle; returns just past the releasing edge
  task automatic wake();
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    #1;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    chk("osc", 1, osc);
    chk("cpu", 1, cpu);
    chk("gie", 0, ia);
    rd(`OFS_PC, 0, "pc");
    rd(`OFS_SP, 0, "sp");
    rd(`OFS_ACC, 0, "acc");
    rd(`OFS_FLAGS, 0, "flags");
    rd(`OFS_STATUS, st(2'h1, 1'b0), "status");
    chk("slverr ok", 0, u_host.rerr);
    rd(8'h1c, 0, "unmapped");
    chk("slverr", 1, u_host.rerr);
    $display("test reset done");
  endtask
  task automatic t_call();
    wr(`OFS_FLAGS, 32'ha);
    wr(`OFS_PC, 32'h123);
    wr(`OFS_SP, 32'h3c);
    cmd(OP_CALL, 1'b0, 8'h00, 12'hfff);
    rd(`OFS_PC, 32'hfff, "call pc");
    rd(`OFS_SP, 32'h3e, "call sp");
    rd(`OFS_STATUS, st(2'h2, 1'b0), "call cycles");
    cmd(OP_RET);
    rd(`OFS_PC, 32'h124, "ret pc");
    rd(`OFS_SP, 32'h3c, "ret sp");
    cmd(OP_CALL, 1'b0, 8'h00, 12'h0a0);
    cmd(OP_RET_IMM, 1'b0, 8'h55);
    rd(`OFS_ACC, 32'h55, "ret imm acc");
    rd(`OFS_PC, 32'h125, "ret imm pc");
    rd(`OFS_FLAGS, 32'ha, "flags kept");
    $display("test call done");
  endtask
  task automatic t_jump();
    cmd(OP_GOTO, 1'b0, 8'h00, 12'h800);
    rd(`OFS_PC, 32'h800, "goto pc");
    wr(`OFS_ACC, 32'h02);
    cmd(OP_PCADD);
    rd(`OFS_PC, 32'h802, "pcadd pc");
    rd(`OFS_STATUS, st(2'h2, 1'b0), "pcadd cycles");
    cmd(OP_NOP);
    rd(`OFS_PC, 32'h803, "nop pc");
    rd(`OFS_ACC, 32'h02, "nop acc");
    rd(`OFS_STATUS, st(2'h1, 1'b0), "nop cycles");
    cmd(OP_SKIP, 1'b1);
    rd(`OFS_PC, 32'h805, "skip pc");
    rd(`OFS_STATUS, st(2'h2, 1'b0), "skip cycles");
    cmd(OP_SKIP, 1'b0);
    rd(`OFS_PC, 32'h806, "noskip pc");
    rd(`OFS_STATUS, st(2'h1, 1'b0), "noskip cycles");
    cmd(OP_IDXM);
    rd(`OFS_STATUS, st(2'h2, 1'b0), "idxm cycles");
    cmd(OP_OTHER);
    rd(`OFS_STATUS, st(2'h1, 1'b0), "other cycles");
    $display("test jump done");
  endtask
  task automatic t_gie();
    cmd(OP_ENGINT);
    #1 chk("engint", 1, ia);
    rd(`OFS_STATUS, st(2'h1, 1'b1), "engint status");
    cmd(OP_DISGINT);
    #1 chk("disgint", 0, ia);
    cmd(OP_CALL, 1'b0, 8'h00, 12'h100);
    cmd(OP_RETI);
    #1 chk("reti early", 0, ia);
    @(posedge pclk);
    #1 chk("reti gie", 1, ia);
    $display("test gie done");
  endtask
  task automatic t_halt();
    logic [31:0] w;
    cmd(OP_STOPEXE);
    #1 chk("exe cpu", 0, cpu);
    chk("exe osc", 1, osc);
    wr(`OFS_PC, 32'h200);
    cmd(OP_GOTO, 1'b0, 8'h00, 12'h321);
    wake();
    chk("exe wake", 1, cpu);
    rd(`OFS_PC, 32'h200, "halted cmd");
    cmd(OP_STOPSYS);
    #1 chk("sys osc", 0, osc);
    chk("sys cpu", 0, cpu);
    repeat (4) @(posedge pclk);
    #1 chk("sys hold", 0, osc);
    u_host.xfer(1'b0, `OFS_WDT, 32'h0);
    w = u_host.rdata;
    rd(`OFS_WDT, w, "wdt frozen");
    wake();
    chk("sys wake", 1, osc);
    $display("test halt done");
  endtask
  task automatic t_soft();
    repeat (40) @(posedge pclk);
    cmd(OP_WDRESET);
    #1 chk("wdt pulse", 1, wclr);
    u_host.xfer(1'b0, `OFS_WDT, 32'h0);
    chk("wdt restart", 1, u_host.rdata < 32'h10);
    cmd(OP_ENGINT);
    wr(`OFS_ACC, 32'h77);
    wr(`OFS_SP, 32'h10);
    cmd(OP_RESET);
    #1 chk("soft pulse", 1, srst);
    chk("soft gie", 0, ia);
    rd(`OFS_PC, 0, "soft pc");
    rd(`OFS_SP, 0, "soft sp");
    rd(`OFS_ACC, 0, "soft acc");
    $display("test soft reset done");
  endtask

  // -----------------------------------------------------------------
  // Clock, watchdog, sequence and verdict
  // -----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  initial begin
    presetn = 1'b0;
    wake_event = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    t_call();
    t_jump();
    t_gie();
    t_halt();
    t_soft();
    end_sim();
  end
endmodule // cpu_flow_system_control_tb_top
